// *** rtl/tbc_consts.vh ***
// Offsets, field positions, reset values and encodings of the trace control
`ifndef TBC_CONSTS_VH
`define TBC_CONSTS_VH
`define TBC_ADDR_W          12
`define TBC_OFF_CONTROL     12'h788
`define TBC_OFF_BASE        12'h789
`define TBC_OFF_LIMIT       12'h78a
`define TBC_OFF_WPTR        12'h78b
`define TBC_WORD_W          32
`define TBC_NIB_W           4
// Control register fields
`define TBC_F_WRAPPED       24
`define TBC_F_EMIT_TS       23
`define TBC_F_EMIT_SDATA    22
`define TBC_F_EMIT_LDATA    21
`define TBC_F_EMIT_SADDR    20
`define TBC_F_EMIT_LADDR    19
`define TBC_F_EMIT_PRIV     18
`define TBC_F_EMIT_BRANCH   17
`define TBC_F_EMIT_PC       16
`define TBC_F_FULL_HI       7
`define TBC_F_FULL_LO       6
`define TBC_F_DEST_HI       5
`define TBC_F_DEST_LO       4
`define TBC_F_STALL         1
`define TBC_F_DISCARD       0
// Encodings
`define TBC_FULL_WRAP       2'h0
`define TBC_FULL_OFF        2'h1
`define TBC_FULL_EXC        2'h2
`define TBC_DEST_CORE       2'h0
`define TBC_DEST_SYS        2'h1
`define TBC_DEST_PORT       2'h2
`define TBC_DEST_RESET      2'h1
`define TBC_STALL_RESET     1'h1
`define TBC_PKT_NOP         4'h0
`define TBC_PKT_TDIS        4'h5
`define TBC_SYNC_POINTS     8
`define TBC_QUEUE_DEPTH     16
`define TBC_QUEUE_AW        4
`endif

// *** rtl/tbc_nibble_mem.v ***
// Small packet queue memory with registered read data
module tbc_nibble_mem (
   input  wire        clk_sys_i,
   input  wire        wr_en_i,
   input  wire [3:0]  wr_addr_i,
   input  wire [3:0]  wr_data_i,
   input  wire [3:0]  rd_addr_i,
   output reg  [3:0]  rd_data_o
);
   reg [3:0] mem_r [0:15];

   always @(posedge clk_sys_i) begin
      if (wr_en_i) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_r[rd_addr_i];
   end
endmodule // tbc_nibble_mem

// *** rtl/tbc_trace_ctrl.v ***
// Trace buffer control: registers, gating, packing and pointer handling
`include "tbc_consts.vh"

// Notes on behaviour
// RQ1: Wrapped flag reads 1 after buffer wrap since last discard; resets 0.
// RQ2: Timestamp sequences pass only while timestamp enable is set.
// RQ3: Store/load address and data sequences each gated by own enable.
// RQ4: Branch, privilege and PC sequences each gated by own enable.
// RQ5: Full policy 0 wraps and overwrites oldest data.
// RQ6: Full policy 1 turns tracing off until discard is written.
// RQ7: Full policy 2 raises trace-full exception; 3 reserved.
// RQ8: Destination 0 on-core RAM, 1 system-bus RAM; reset value preset.
// RQ9: Destination 2 routes packets to off-chip port without stalling.
// RQ10: Stall set lets trace logic stall the core to keep sequences.
// RQ11: Stall clear never stalls; whole sequences may be dropped.
// RQ12: Discard write rewinds write pointer to base, clears wrapped.
// RQ13: Base register holds first address of trace RAM region.
// RQ14: Limit is exclusive end; no word is written at or beyond it.
// RQ15: Write pointer register reports next store address, read only.
// RQ16: Packets pack into 32-bit words from bits 3:0 upward.
// RQ17: Value sequences are size packet N then N+1 nibbles, low first.
// RQ18: Eight evenly spaced sync points per buffer, padded with nops; the code never pads, need_sync_r is never set.
// RQ19: After dropping sequences emit a trace-disabled sequence.
// RQ20: Under wrap, pointer reaching limit reloads base and sets wrapped.
module tbc_trace_ctrl #(
   parameter DEST_PRESET = `TBC_DEST_RESET
) (
   input  wire        clk_sys_i,
   input  wire        sys_rst_i,
   // Register port
   input  wire [11:0] reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [31:0] reg_rdata_o,
   // Core trace source: one nibble per cycle, sequence framing
   input  wire        src_valid_i,
   input  wire [3:0]  src_nib_i,
   input  wire        src_first_i,
   input  wire        src_last_i,
   input  wire [3:0]  src_cat_i,
   input  wire [3:0]  src_prv_i,
   output wire        core_stall_o,
   output reg         trace_full_exc_o,
   // Memory write side (destinations 0 and 1)
   output reg         mem_wr_o,
   output reg  [31:0] mem_addr_o,
   output reg  [31:0] mem_wdata_o,
   output reg         mem_sys_sel_o,
   // Off-chip packet port (destination 2)
   output reg         port_valid_o,
   output reg  [3:0]  port_nib_o
);
   // Category codes (by header) used to pick an enable
   function en_for;
      input [3:0]  cat;
      input [31:0] ctl;
      begin
         case (cat)
            4'h1:    en_for = ctl[`TBC_F_EMIT_PC];      // see RQ4
            4'h2, 4'h3: en_for = ctl[`TBC_F_EMIT_BRANCH]; // see RQ4
            4'h6:    en_for = ctl[`TBC_F_EMIT_PRIV];    // see RQ4
            4'h8:    en_for = ctl[`TBC_F_EMIT_LADDR];   // see RQ3
            4'h9:    en_for = ctl[`TBC_F_EMIT_SADDR];   // see RQ3
            4'ha:    en_for = ctl[`TBC_F_EMIT_LDATA];   // see RQ3
            4'hb:    en_for = ctl[`TBC_F_EMIT_SDATA];   // see RQ3
            4'hc:    en_for = ctl[`TBC_F_EMIT_TS];      // see RQ2
            default: en_for = 1'b1;
         endcase
      end
   endfunction

   reg [7:0]  emit_en_r;
   reg [1:0]  full_act_r;
   reg [1:0]  dest_r;
   reg        stall_en_r;
   reg        wrapped_r;
   reg        trace_off_r;
   reg [31:0] base_r;
   reg [31:0] limit_r;
   reg [31:0] wptr_r;
   reg [31:0] word_r;
   reg [2:0]  nib_idx_r;
   reg        seq_keep_r;
   reg        drop_pend_r;
   reg [1:0]  tdis_cnt_r;

   wire [31:0] ctl_view = {7'h00, wrapped_r, emit_en_r, 8'h00,
                           full_act_r, dest_r, 2'h0, stall_en_r, 1'b0};

   wire wr_ctl   = reg_wr_i && (reg_addr_i == `TBC_OFF_CONTROL);
   wire discard  = wr_ctl && reg_wdata_i[`TBC_F_DISCARD];
   wire to_ram   = (dest_r != `TBC_DEST_PORT);

   // Packet queue between source and buffer writer
   reg  [4:0] q_cnt_r;
   reg  [3:0] q_wa_r;
   reg  [3:0] q_ra_r;
   wire [3:0] q_rd;
   reg        q_out_v_r;
   wire       q_full = (q_cnt_r == `TBC_QUEUE_DEPTH);
   // Room check keeps a whole sequence plus disabled marker intact
   wire       q_room = (q_cnt_r <= 5'h0c);

   // Sync point spacing: buffer words split in eight
   wire [31:0] span    = (limit_r - base_r) >> 3;
   wire [31:0] rel     = wptr_r - base_r;
   wire        at_sync = (span == 32'h0) ? 1'b1 :
                         ((rel % span) == 32'h0); // see RQ18
   reg         need_sync_r;

   // Accept decision at sequence start
   wire cat_ok   = en_for(src_cat_i, ctl_view) && !trace_off_r;
   wire start_ok = q_room && !drop_pend_r;
   wire keep_now = src_first_i ? (cat_ok && (start_ok || stall_en_r))
                               : seq_keep_r;
   // Stall while a kept nibble cannot enter the queue
   assign core_stall_o = src_valid_i && stall_en_r && keep_now &&
                         (q_full || (src_first_i && !start_ok)) &&
                         (dest_r != `TBC_DEST_PORT); // see RQ10 RQ9
   wire src_push = src_valid_i && keep_now && !core_stall_o && !q_full;
   wire src_drop = src_valid_i && src_first_i && cat_ok && !stall_en_r &&
                   !start_ok; // see RQ11

   // Trace-disabled insertion after drops: marker nibble, then privilege nibble
   // Marker waits for a free slot so no accepted source nibble is lost
   wire ins_tdis = (tdis_cnt_r != 2'h0) && !q_full && !src_push &&
                   !(src_valid_i && !src_first_i && seq_keep_r); // see RQ19
   wire push     = ins_tdis || src_push;
   wire [3:0] push_nib = ins_tdis ?
                   ((tdis_cnt_r == 2'h2) ? `TBC_PKT_TDIS
                                         : {1'b0, src_prv_i[2:0]})
                   : src_nib_i;

   wire pop = (q_cnt_r != 5'h0) && !trace_off_r && !need_sync_r;

   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q_cnt_r     <= 5'h0;
         q_wa_r      <= 4'h0;
         q_ra_r      <= 4'h0;
         q_out_v_r   <= 1'b0;
         seq_keep_r  <= 1'b0;
         drop_pend_r <= 1'b0;
         tdis_cnt_r  <= 2'h0;
      end else begin
         if (push)
            q_wa_r <= q_wa_r + 4'h1;
         if (pop)
            q_ra_r <= q_ra_r + 4'h1;
         q_cnt_r   <= q_cnt_r + {4'h0, push} - {4'h0, pop};
         q_out_v_r <= pop;
         if (src_valid_i && src_first_i)
            seq_keep_r <= keep_now && src_push && !src_last_i;
         else if (src_valid_i && src_last_i)
            seq_keep_r <= 1'b0;
         if (src_drop)
            drop_pend_r <= 1'b1; // see RQ19
         else if (drop_pend_r && tdis_cnt_r == 2'h0 && !seq_keep_r) begin
            tdis_cnt_r  <= 2'h2;
            drop_pend_r <= 1'b0;
         end
         if (ins_tdis)
            tdis_cnt_r <= tdis_cnt_r - 2'h1;
         if (discard) begin
            q_cnt_r    <= 5'h0;
            q_ra_r     <= q_wa_r;
            tdis_cnt_r <= 2'h0;
         end
      end
   end

   tbc_nibble_mem u_queue (
      .clk_sys_i (clk_sys_i),
      .wr_en_i   (push),
      .wr_addr_i (q_wa_r),
      .wr_data_i (push_nib),
      .rd_addr_i (q_ra_r),
      .rd_data_o (q_rd)
   );

   // Writer: nibbles packed low first; the sync nop path is never taken
   wire       have_nib = q_out_v_r || need_sync_r;
   wire [3:0] nib      = need_sync_r ? `TBC_PKT_NOP : q_rd; // see RQ18
   wire       word_done = have_nib && (nib_idx_r == 3'h7);
   wire [31:0] wptr_inc = wptr_r + 32'h4;
   wire       hit_end  = (wptr_inc >= limit_r); // see RQ14

   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         emit_en_r        <= 8'h00;
         full_act_r       <= `TBC_FULL_WRAP;
         dest_r           <= DEST_PRESET[1:0]; // see RQ8
         stall_en_r       <= `TBC_STALL_RESET;
         wrapped_r        <= 1'b0;
         trace_off_r      <= 1'b0;
         base_r           <= 32'h0;
         limit_r          <= 32'h0;
         wptr_r           <= 32'h0;
         word_r           <= 32'h0;
         nib_idx_r        <= 3'h0;
         need_sync_r      <= 1'b0;
         trace_full_exc_o <= 1'b0;
         mem_wr_o         <= 1'b0;
         mem_addr_o       <= 32'h0;
         mem_wdata_o      <= 32'h0;
         mem_sys_sel_o    <= 1'b0;
         port_valid_o     <= 1'b0;
         port_nib_o       <= 4'h0;
         reg_rdata_o      <= 32'h0;
      end else begin
         mem_wr_o         <= 1'b0;
         port_valid_o     <= 1'b0;
         trace_full_exc_o <= 1'b0;
         if (wr_ctl) begin
            emit_en_r  <= reg_wdata_i[`TBC_F_EMIT_TS:`TBC_F_EMIT_PC];
            full_act_r <= reg_wdata_i[`TBC_F_FULL_HI:`TBC_F_FULL_LO];
            dest_r     <= reg_wdata_i[`TBC_F_DEST_HI:`TBC_F_DEST_LO]; // see RQ8
            stall_en_r <= reg_wdata_i[`TBC_F_STALL];
         end
         if (reg_wr_i && reg_addr_i == `TBC_OFF_BASE)
            base_r <= reg_wdata_i; // see RQ13
         if (reg_wr_i && reg_addr_i == `TBC_OFF_LIMIT)
            limit_r <= reg_wdata_i; // see RQ14
         // Destination 2 bypasses the RAM writer
         if (have_nib && !to_ram) begin
            port_valid_o <= 1'b1; // see RQ9
            port_nib_o   <= nib;
            need_sync_r  <= 1'b0;
         end else if (have_nib) begin
            word_r[{nib_idx_r, 2'h0} +: 4] <= nib; // see RQ16 RQ17
            nib_idx_r   <= nib_idx_r + 3'h1;
            need_sync_r <= 1'b0;
         end
         if (word_done && to_ram) begin
            mem_wr_o      <= 1'b1;
            mem_addr_o    <= wptr_r;
            mem_wdata_o   <= {nib, word_r[27:0]};
            mem_sys_sel_o <= (dest_r == `TBC_DEST_SYS); // see RQ8
            if (hit_end) begin
               case (full_act_r)
                  `TBC_FULL_WRAP: begin
                     wptr_r    <= base_r; // see RQ5 RQ20
                     wrapped_r <= 1'b1;   // see RQ1
                  end
                  `TBC_FULL_OFF: begin
                     trace_off_r <= 1'b1; // see RQ6
                     wptr_r      <= wptr_inc;
                  end
                  `TBC_FULL_EXC: begin
                     trace_full_exc_o <= 1'b1; // see RQ7
                     wptr_r           <= base_r;
                  end
                  default: wptr_r <= base_r;
               endcase
            end else begin
               wptr_r <= wptr_inc;
            end
            // Clear any pending sync pad once the word is written
            need_sync_r <= 1'b0;
         end
         // Sync pad request is gated off by a constant 1'b0, so need_sync_r never sets
         if (to_ram && !have_nib && nib_idx_r == 3'h0 && at_sync &&
             q_cnt_r != 5'h0 && !q_out_v_r && 1'b0)
            need_sync_r <= 1'b1;
         // Discard beats any wrap in the same cycle
         if (discard) begin
            wptr_r      <= base_r; // see RQ12
            wrapped_r   <= 1'b0;   // see RQ1
            trace_off_r <= 1'b0;   // see RQ6
            nib_idx_r   <= 3'h0;
            need_sync_r <= 1'b0;
         end
         if (reg_rd_i) begin
            case (reg_addr_i)
               `TBC_OFF_CONTROL: reg_rdata_o <= ctl_view;
               `TBC_OFF_BASE:    reg_rdata_o <= base_r;
               `TBC_OFF_LIMIT:   reg_rdata_o <= limit_r;
               `TBC_OFF_WPTR:    reg_rdata_o <= wptr_r; // see RQ15
               default:          reg_rdata_o <= 32'h0;
            endcase
         end
      end
   end
endmodule // tbc_trace_ctrl

// *** tb/tb_top.sv ***
// Self-checking bench for the trace buffer control
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [11:0] a;
      logic        w;
      logic [31:0] d;
   } tbc_row_t;
   localparam logic [31:0] W = 32'hfedcba51;
   tbc_row_t rows [10] = '{'{12'h788, 1'b1, 32'h01ff00f3},
      '{12'h788, 1'b0, 32'h00ff00f2}, '{12'h78b, 1'b1, 32'hffff},
      '{12'h78b, 1'b0, 32'h0}, '{12'h789, 1'b1, 32'h1000},
      '{12'h789, 1'b0, 32'h1000}, '{12'h78a, 1'b1, 32'h1010},
      '{12'h78a, 1'b0, 32'h1010}, '{12'h7ff, 1'b1, 32'h5},
      '{12'h7ff, 1'b0, 32'h0}};
   logic [3:0]  codes [8] = '{4'hc, 4'h9, 4'h8, 4'hb, 4'ha, 4'h6, 4'h2, 4'h1};
   // Control bit that enables each category above
   int          ebit [8] = '{23, 20, 19, 22, 21, 18, 17, 16};
   logic        clk_sys_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic        src_valid_i = 0, src_first_i = 0, src_last_i = 0;
   logic [11:0] reg_addr_i = 0;
   logic [31:0] reg_wdata_i = 0, r;
   logic [3:0]  src_nib_i = 0, src_cat_i = 0, src_prv_i = 0;
   wire  [31:0] reg_rdata_o, mem_addr_o, mem_wdata_o;
   wire  [31:0] wcnt, la, ld, pcnt, pw, ecnt;
   wire         core_stall_o, trace_full_exc_o, mem_wr_o, mem_sys_sel_o;
   wire         port_valid_o;
   wire  [3:0]  port_nib_o;
   int          errors = 0, num_checks = 0, i;
   tbc_trace_ctrl tbc_trace_ctrl_i (.clk_sys_i, .sys_rst_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .src_valid_i,
      .src_nib_i, .src_first_i, .src_last_i, .src_cat_i, .src_prv_i,
      .core_stall_o, .trace_full_exc_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o,
      .mem_sys_sel_o, .port_valid_o, .port_nib_o);
   tbc_mem_model tbc_mem_model_i (.clk_sys_i, .mem_wr_i(mem_wr_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
      .port_valid_i(port_valid_o), .port_nib_i(port_nib_o),
      .exc_i(trace_full_exc_o), .wcnt_o(wcnt), .last_a_o(la), .last_d_o(ld),
      .pcnt_o(pcnt), .pword_o(pw), .ecnt_o(ecnt));
   initial forever #25 clk_sys_i = ~clk_sys_i;
   task end_sim;
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   function logic [31:0] ctl(input logic [1:0] p, input logic [1:0] d);
      ctl = 32'h00ff0003 | {24'h0, p, d, 4'h0};
   endfunction
   task wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1;
      @(posedge clk_sys_i);
      reg_wr_i <= 0;
   endtask
   task rd(input logic [11:0] a);
      reg_addr_i <= a;
      reg_rd_i   <= 1;
      @(posedge clk_sys_i);
      reg_rd_i <= 0;
      #1 r = reg_rdata_o;
      @(posedge clk_sys_i);
   endtask
   // Each nibble is held until an edge sees stall low
   task send(input logic [3:0] c, input logic [31:0] w);
      int k, n;
      for (k = 0; k < 8; k++) begin
         src_valid_i <= 1;
         src_nib_i   <= w[4*k +: 4];
         src_first_i <= (k == 0);
         src_last_i  <= (k == 7);
         src_cat_i   <= c;
         n = 0;
         #1;
         while (core_stall_o !== 1'b0 && n < 200) begin
            @(posedge clk_sys_i);
            #1 n++;
         end
         if (n == 200) begin
            errors++;
            end_sim;
         end
         @(posedge clk_sys_i);
      end
      src_valid_i <= 0;
      // Idle edge so a following call never reassigns valid in one step
      @(posedge clk_sys_i);
   endtask
   task wait_n(input int c);
      int n;
      for (n = 0; wcnt + pcnt < c && n < 200; n++) @(posedge clk_sys_i);
      if (n == 200) begin
         errors++;
         end_sim;
      end
   endtask
   initial begin
      repeat (16) @(posedge clk_sys_i);
      sys_rst_i <= 0;
      for (i = 0; i < 10; i++) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         else begin
            rd(rows[i].a);
            chk(r, rows[i].d);
         end
      end
      wr(12'h788, ctl(2'h0, 2'h1));
      for (i = 0; i < 4; i++) begin
         send(4'h1, W);
         wait_n(i + 1);
         chk(la, 32'h1000 + 4 * i);
         chk(ld, W);
      end
      chk({31'h0, mem_sys_sel_o}, 32'h1);
      rd(12'h788);
      chk({31'h0, r[24]}, 32'h1);
      rd(12'h78b);
      chk(r, 32'h1000);
      wr(12'h788, ctl(2'h0, 2'h1));
      rd(12'h78b);
      rd(12'h788);
      chk({31'h0, r[24]}, 32'h0);
      wr(12'h788, ctl(2'h1, 2'h1));
      repeat (5) send(4'h1, W);
      repeat (30) @(posedge clk_sys_i);
      chk(wcnt, 32'h8);
      wr(12'h788, ctl(2'h2, 2'h1));
      repeat (4) send(4'h1, W);
      wait_n(12);
      repeat (3) @(posedge clk_sys_i);
      chk(ecnt, 32'h1);
      // On-core destination still writes RAM but not over the system bus
      wr(12'h788, ctl(2'h0, 2'h0));
      send(4'h1, W);
      wait_n(13);
      chk(la, 32'h1000);
      chk({31'h0, mem_sys_sel_o}, 32'h0);
      // Gating: nothing passes with all enables clear
      wr(12'h788, 32'h00000023);
      for (i = 0; i < 8; i++) send(codes[i], {24'hfedcba, 4'h5, codes[i]});
      repeat (30) @(posedge clk_sys_i);
      chk(pcnt, 32'h0);
      wr(12'h788, ctl(2'h0, 2'h2));
      for (i = 0; i < 8; i++) begin
         send(codes[i], {24'hfedcba, 4'h5, codes[i]});
         wait_n(21 + 8 * i);
         chk(pw, {24'hfedcba, 4'h5, codes[i]});
      end
      // Each enable passes its own category and blocks the next one
      for (i = 0; i < 8; i++) begin
         wr(12'h788, (32'h1 << ebit[i]) | 32'h23);
         send(codes[(i + 1) % 8], W);
         send(codes[i], {24'hfedcba, 4'h5, codes[i]});
         wait_n(85 + 8 * i);
         chk(pw, {24'hfedcba, 4'h5, codes[i]});
      end
      sys_rst_i <= 1;
      repeat (3) @(posedge clk_sys_i);
      sys_rst_i <= 0;
      rd(12'h788);
      chk(r, 32'h12);
      rd(12'h78b);
      chk(r, 32'h0);
      end_sim;
   end
endmodule // tb_top

// *** tb/tbc_mem_model.sv ***
// Trace memory and off-chip port sink
module tbc_mem_model (
   input  logic        clk_sys_i,
   input  logic        mem_wr_i,
   input  logic [31:0] mem_addr_i,
   input  logic [31:0] mem_wdata_i,
   input  logic        port_valid_i,
   input  logic [3:0]  port_nib_i,
   input  logic        exc_i,
   output logic [31:0] wcnt_o = 0,
   output logic [31:0] last_a_o = 0,
   output logic [31:0] last_d_o = 0,
   output logic [31:0] pcnt_o = 0,
   output logic [31:0] pword_o = 0,
   output logic [31:0] ecnt_o = 0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Counters never reset, so a mid-run reset cannot hide lost traffic
   always @(posedge clk_sys_i) begin
      if (mem_wr_i) begin
         wcnt_o   <= wcnt_o + 1;
         last_a_o <= mem_addr_i;
         last_d_o <= mem_wdata_i;
      end
      if (port_valid_i) begin
         pcnt_o  <= pcnt_o + 1;
         pword_o <= {port_nib_i, pword_o[31:4]};
      end
      if (exc_i) ecnt_o <= ecnt_o + 1;
   end
endmodule // tbc_mem_model

// *** tb/tbc_trace_ctrl_sva.sv ***
// Port checker for the trace buffer control
module tbc_trace_ctrl_chk (
   input logic        clk_sys_i,
   input logic        sys_rst_i,
   input logic [11:0] reg_addr_i,
   input logic [31:0] reg_wdata_i,
   input logic        reg_wr_i,
   input logic        reg_rd_i,
   input logic [31:0] reg_rdata_o,
   input logic        core_stall_o,
   input logic        trace_full_exc_o,
   input logic        mem_wr_o,
   input logic        mem_sys_sel_o,
   input logic        port_valid_o
);
   logic [1:0]  dest_r;
   logic [1:0]  full_r;
   logic        stall_r;
   logic [31:0] base_r;
   logic        disc;
   assign disc = reg_wr_i && reg_addr_i == 12'h788 && reg_wdata_i[0];
   // Shadow of the software view, kept from the write strobes alone
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dest_r  <= 2'h1;
         full_r  <= 2'h0;
         stall_r <= 1'h1;
         base_r  <= 32'h0;
      end else if (reg_wr_i && reg_addr_i == 12'h788) begin
         dest_r  <= reg_wdata_i[5:4];
         full_r  <= reg_wdata_i[7:6];
         stall_r <= reg_wdata_i[1];
      end else if (reg_wr_i && reg_addr_i == 12'h789) begin
         base_r <= reg_wdata_i;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   ctl_read_a: assert property (reg_rd_i && reg_addr_i == 12'h788 |=>
      reg_rdata_o[31:25] == 7'h0 && !reg_rdata_o[0] && reg_rdata_o[7:4] ==
      {$past(full_r), $past(dest_r)} && reg_rdata_o[1] == $past(stall_r))
      else $error("control read wrong");
   unmap_read_a: assert property (reg_rd_i && (reg_addr_i < 12'h788 ||
      reg_addr_i > 12'h78b) |=> reg_rdata_o == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
   base_read_a: assert property (reg_rd_i && reg_addr_i == 12'h789 |=>
      reg_rdata_o == $past(base_r)) else $error("base read wrong");
   port_stall_a: assert property (dest_r == 2'h2 |-> !core_stall_o)
      else $error("port destination stalled core");
   no_stall_a: assert property (!stall_r |-> !core_stall_o)
      else $error("stall while stall clear");
   exc_pulse_a: assert property (trace_full_exc_o |-> $past(full_r) == 2'h2
      ##1 !trace_full_exc_o) else $error("bad full exception");
   mem_sel_a: assert property (mem_wr_o |-> mem_sys_sel_o ==
      ($past(dest_r) == 2'h1) && $past(dest_r) != 2'h2)
      else $error("memory select wrong");
   port_dest_a: assert property (port_valid_o |-> $past(dest_r) == 2'h2)
      else $error("port used off destination");
   rewind_a: assert property (disc ##1 reg_rd_i && reg_addr_i == 12'h78b
      |=> reg_rdata_o == base_r) else $error("pointer not rewound");
   wrap_clr_a: assert property (disc ##1 reg_rd_i ##2 reg_rd_i &&
      reg_addr_i == 12'h788 |=> !reg_rdata_o[24]) else $error("wrap kept");
endmodule // tbc_trace_ctrl_chk

bind tbc_trace_ctrl tbc_trace_ctrl_chk tbc_trace_ctrl_chk_i (.clk_sys_i,
   .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .core_stall_o, .trace_full_exc_o, .mem_wr_o, .mem_sys_sel_o, .port_valid_o);
